// [rtl/task_file_port.sv]
module task_file_port
    import task_file_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Host register access
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Drive core side
    input wire logic dev_id,
    input wire logic drive_ready,
    input wire drive_status_t drv_status,
    input wire logic cmd_done,
    input wire logic cmd_err,
    output logic cmd_start,
    output cmd_req_t cmd_req,
    output logic soft_reset,
    // Interrupt pin
    output logic intrq_out,
    output logic intrq_oe
);
    logic [7:0] features_r, features_nxt, sec_count_r, sec_count_nxt, sec_num_r, sec_num_nxt;
    logic [7:0] cyl_lo_r, cyl_lo_nxt, cyl_hi_r, cyl_hi_nxt, drv_head_r, drv_head_nxt;
    logic srst_r, srst_nxt, ien_r, ien_nxt, bsy_r, bsy_nxt, in_reset_r, in_reset_nxt;
    logic err_r, err_nxt, abrt_r, abrt_nxt, intrq_r, intrq_nxt, oe_r, oe_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt, cmd_start_r, cmd_start_nxt;
    cmd_req_t cmd_req_r, cmd_req_nxt;
    logic sel0, sel1, cmd_wr, cmd_ok, op_valid, op_long;
    logic [7:0] status;
    param_use_t use_mask;

    opcode_decoder u_dec (
        .opcode(wr_data),
        .valid(op_valid),
        .long_xfer(op_long),
        .use_mask(use_mask)
    );

    assign sel0 = !cs0_n && cs1_n;
    assign sel1 = cs0_n && !cs1_n;
    assign cmd_wr = wr_en && sel0 && (addr == ADDR_COMMAND);
    assign cmd_ok = cmd_wr && !bsy_r && drive_ready;
    assign status = {bsy_r, drive_ready, drv_status.df, drv_status.dsc, drv_status.drq,
                     STATUS_CORR_VALUE, drv_status.idx, err_r};

    always_comb begin
        features_nxt = features_r;
        sec_count_nxt = sec_count_r;
        sec_num_nxt = sec_num_r;
        cyl_lo_nxt = cyl_lo_r;
        cyl_hi_nxt = cyl_hi_r;
        drv_head_nxt = drv_head_r;
        srst_nxt = srst_r;
        ien_nxt = ien_r;
        bsy_nxt = bsy_r;
        in_reset_nxt = in_reset_r;
        err_nxt = err_r;
        abrt_nxt = abrt_r;
        intrq_nxt = intrq_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        cmd_start_nxt = 1'b0;
        cmd_req_nxt = cmd_req_r;
        // Bits 7-4, 3 and 0 are not stored
        if (wr_en && sel1 && (addr == ADDR_DEVICE_CONTROL)) begin
            srst_nxt = wr_data[DC_SRST_BIT];
            ien_nxt = wr_data[DC_IEN_BIT];
        end
        // Reads; busy forces status onto every register
        if (rd_en && (sel0 || sel1)) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = BYTE_ZERO;
            if (bsy_r) begin
                rd_data_nxt = status;
            end else if (sel1) begin
                if (addr == ADDR_ALT_STATUS) begin
                    rd_data_nxt = status;
                end
            end else begin
                case (addr)
                    ADDR_ERROR: rd_data_nxt = {5'h00, abrt_r, 2'h0};
                    ADDR_SECTOR_COUNT: rd_data_nxt = sec_count_r;
                    ADDR_SECTOR_NUMBER: rd_data_nxt = sec_num_r;
                    ADDR_CYL_LOW: rd_data_nxt = cyl_lo_r;
                    ADDR_CYL_HIGH: rd_data_nxt = cyl_hi_r;
                    ADDR_DRIVE_HEAD: rd_data_nxt = drv_head_r;
                    ADDR_STATUS: begin
                        rd_data_nxt = status;
                        intrq_nxt = 1'b0;
                    end
                    default: rd_data_nxt = BYTE_ZERO;
                endcase
            end
        end
        // Parameter writes, refused while busy
        if (wr_en && sel0 && !bsy_r) begin
            case (addr)
                ADDR_FEATURES: features_nxt = wr_data;
                ADDR_SECTOR_COUNT: sec_count_nxt = wr_data;
                ADDR_SECTOR_NUMBER: sec_num_nxt = wr_data;
                ADDR_CYL_LOW: cyl_lo_nxt = wr_data;
                ADDR_CYL_HIGH: cyl_hi_nxt = wr_data;
                ADDR_DRIVE_HEAD: drv_head_nxt = wr_data;
                default: ;
            endcase
        end
        if (cmd_ok) begin
            intrq_nxt = 1'b0;
            err_nxt = !op_valid;
            abrt_nxt = !op_valid;
            if (op_valid) begin
                bsy_nxt = 1'b1;
                cmd_start_nxt = 1'b1;
                cmd_req_nxt.opcode = wr_data;
                cmd_req_nxt.long_xfer = op_long;
                // Unused parameters pass as zero
                cmd_req_nxt.params.sector_count_param = use_mask.sc ? sec_count_r : BYTE_ZERO;
                cmd_req_nxt.params.sector_number_param = use_mask.sn ? sec_num_r : BYTE_ZERO;
                cmd_req_nxt.params.cylinder_param = use_mask.cy ? {cyl_hi_r, cyl_lo_r} : {BYTE_ZERO, BYTE_ZERO};
                cmd_req_nxt.params.drive_select_param = use_mask.drv ? drv_head_r[DH_DRV_BIT] : 1'b0;
                cmd_req_nxt.params.head_select_param =
                    use_mask.hd ? drv_head_r[DH_HEAD_MSB:DH_HEAD_LSB] : 4'h0;
                cmd_req_nxt.params.feature_param = use_mask.ft ? features_r : BYTE_ZERO;
            end else begin
                intrq_nxt = 1'b1;
            end
        end
        // Completion of a running command; set wins over a status read
        if (cmd_done && bsy_r && !in_reset_r) begin
            bsy_nxt = 1'b0;
            err_nxt = cmd_err;
            intrq_nxt = 1'b1;
        end
        // Soft reset, whatever drive is selected
        if (srst_r) begin
            features_nxt = BYTE_ZERO;
            sec_count_nxt = BYTE_ZERO;
            sec_num_nxt = BYTE_ZERO;
            cyl_lo_nxt = BYTE_ZERO;
            cyl_hi_nxt = BYTE_ZERO;
            drv_head_nxt = BYTE_ZERO;
            err_nxt = 1'b0;
            abrt_nxt = 1'b0;
            intrq_nxt = 1'b0;
            cmd_start_nxt = 1'b0;
            bsy_nxt = 1'b1;
            in_reset_nxt = 1'b1;
        end else if (in_reset_r) begin
            bsy_nxt = 1'b0;
            in_reset_nxt = 1'b0;
        end
        oe_nxt = !ien_r && (drv_head_r[DH_DRV_BIT] == dev_id);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            features_r <= BYTE_ZERO;
            sec_count_r <= BYTE_ZERO;
            sec_num_r <= BYTE_ZERO;
            cyl_lo_r <= BYTE_ZERO;
            cyl_hi_r <= BYTE_ZERO;
            drv_head_r <= BYTE_ZERO;
            srst_r <= 1'b0;
            ien_r <= 1'b0;
            bsy_r <= 1'b0;
            in_reset_r <= 1'b0;
            err_r <= 1'b0;
            abrt_r <= 1'b0;
            intrq_r <= 1'b0;
            oe_r <= 1'b0;
            rd_data_r <= BYTE_ZERO;
            rd_valid_r <= 1'b0;
            cmd_start_r <= 1'b0;
            cmd_req_r <= '0;
        end else begin
            features_r <= features_nxt;
            sec_count_r <= sec_count_nxt;
            sec_num_r <= sec_num_nxt;
            cyl_lo_r <= cyl_lo_nxt;
            cyl_hi_r <= cyl_hi_nxt;
            drv_head_r <= drv_head_nxt;
            srst_r <= srst_nxt;
            ien_r <= ien_nxt;
            bsy_r <= bsy_nxt;
            in_reset_r <= in_reset_nxt;
            err_r <= err_nxt;
            abrt_r <= abrt_nxt;
            intrq_r <= intrq_nxt;
            oe_r <= oe_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            cmd_start_r <= cmd_start_nxt;
            cmd_req_r <= cmd_req_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign cmd_start = cmd_start_r;
    assign cmd_req = cmd_req_r;
    assign soft_reset = srst_r;
    assign intrq_out = intrq_r;
    assign intrq_oe = oe_r;

    sequence good_cmd_s;
        cmd_ok && op_valid && !srst_r;
    endsequence
    sequence bad_cmd_s;
        cmd_ok && !op_valid && !srst_r;
    endsequence
    sequence srst_held_s;
        srst_r [*2];
    endsequence

    cmd_refused_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_wr && (bsy_r || !drive_ready)) |=> !cmd_start_r && ($stable(err_r) || srst_r || $past(cmd_done)))
        else $error("command taken while busy or not ready");
    cmd_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        good_cmd_s |=> cmd_start_r && bsy_r && !intrq_r ##1 !cmd_start_r)
        else $error("valid command did not start");
    cmd_abort_a: assert property (@(posedge sys_clk) disable iff (rst)
        bad_cmd_s |=> err_r && abrt_r && intrq_r && !bsy_r && !cmd_start_r)
        else $error("undefined opcode not aborted");
    alt_status_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && sel1 && addr == ADDR_ALT_STATUS && intrq_r && !srst_r && !cmd_wr)
        |=> intrq_r && rd_valid_r && rd_data_r == $past(status))
        else $error("alternate status read disturbed interrupt");
    status_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && sel0 && addr == ADDR_STATUS && !bsy_r && !cmd_ok) |=> !intrq_r)
        else $error("status read did not clear interrupt");
    srst_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
        srst_held_s |=> bsy_r && sec_count_r == BYTE_ZERO && !intrq_r && !cmd_start_r)
        else $error("soft reset did not hold busy and clear");
    ien_float_a: assert property (@(posedge sys_clk) disable iff (rst)
        ien_r |=> !intrq_oe)
        else $error("interrupt pin driven while disabled");
    busy_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && (sel0 || sel1) && bsy_r) |=> rd_data_r == $past(status))
        else $error("busy read returned non-status");
    unused_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        (good_cmd_s ##0 !use_mask.ft) |=> cmd_req_r.params.feature_param == BYTE_ZERO)
        else $error("unused feature parameter passed on");
    drive_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        good_cmd_s |=> cmd_req_r.params.drive_select_param == $past(drv_head_r[DH_DRV_BIT]))
        else $error("drive select not from drive/head bit");
endmodule // task_file_port

// [rtl/task_file_pkg.sv]
// Behaviour
// - A command starts only when busy is clear and ready is set at write.
// - An undefined opcode ends with an aborted-command error.
// - A command write taken while not busy and ready clears a pending interrupt request; an undefined opcode sets it again.
// - Decoder accepts the listed opcodes except F0 and F7, including nibble ranges and alternate power codes.
// - Long transfer pairs carry the long flag; zero means a normal transfer.
// - F8 reads native maximum address; F9 sets it using count, number, cylinder, drive and head parameters, not features.
// - Parameters marked required hold host values written before the opcode.
// - Parameters marked unused are ignored and passed on as zero.
// - Drive select comes from drive/head bit 4, head from bits 3-0.
// - Cylinder joins low and high bytes; feature comes from the features register.
// - Alternate status read returns status and leaves the interrupt pending.
// - Soft reset bit holds the device in reset, sets busy, clears registers.
// - Soft reset acts whatever drive is selected.
// - Interrupt disable set floats the interrupt pin; clear and selected drives it.
// - Reading main status while interrupt pending clears it.
// - While busy, any register read returns status contents.
package task_file_pkg;
    // Task-file addresses
    localparam logic [2:0] ADDR_ERROR = 3'h1;
    localparam logic [2:0] ADDR_FEATURES = 3'h1;
    localparam logic [2:0] ADDR_SECTOR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_SECTOR_NUMBER = 3'h3;
    localparam logic [2:0] ADDR_CYL_LOW = 3'h4;
    localparam logic [2:0] ADDR_CYL_HIGH = 3'h5;
    localparam logic [2:0] ADDR_DRIVE_HEAD = 3'h6;
    localparam logic [2:0] ADDR_COMMAND = 3'h7;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;
    localparam logic [2:0] ADDR_DEVICE_CONTROL = 3'h6;

    // Field positions
    localparam int DC_SRST_BIT = 2;
    localparam int DC_IEN_BIT = 1;
    localparam int DH_DRV_BIT = 4;
    localparam int DH_HEAD_MSB = 3;
    localparam int DH_HEAD_LSB = 0;
    localparam int ERR_ABRT_BIT = 2;
    localparam int LONG_BIT = 1;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic STATUS_CORR_VALUE = 1'b0;

    // Opcodes and opcode patterns
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_RECAL = 8'h1?;
    localparam logic [7:0] OP_RW_SECTORS = 8'b0010_00??;
    localparam logic [7:0] OP_WR_SECTORS = 8'b0011_00??;
    localparam logic [7:0] OP_WR_VERIFY = 8'h3c;
    localparam logic [7:0] OP_RD_VERIFY = 8'b0100_000?;
    localparam logic [7:0] OP_FORMAT = 8'h50;
    localparam logic [7:0] OP_SEEK = 8'h7?;
    localparam logic [7:0] OP_DIAG = 8'h90;
    localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
    localparam logic [7:0] OP_PWR_ALT_LO = 8'b1001_01??;
    localparam logic [7:0] OP_PWR_ALT_HI = 8'b1001_100?;
    localparam logic [7:0] OP_SMART = 8'hb0;
    localparam logic [7:0] OP_RW_MULTIPLE = 8'b1100_010?;
    localparam logic [7:0] OP_SET_MULTIPLE = 8'hc6;
    localparam logic [7:0] OP_DMA = 8'b1100_10??;
    localparam logic [7:0] OP_PWR_MAIN = 8'b1110_00??;
    localparam logic [7:0] OP_CHECK_PWR = 8'he5;
    localparam logic [7:0] OP_SLEEP = 8'he6;
    localparam logic [7:0] OP_RD_BUFFER = 8'he4;
    localparam logic [7:0] OP_FLUSH = 8'he7;
    localparam logic [7:0] OP_WR_BUFFER = 8'he8;
    localparam logic [7:0] OP_IDENTIFY = 8'hec;
    localparam logic [7:0] OP_SET_FEATURES = 8'hef;
    localparam logic [7:0] OP_SECURITY = 8'b1111_0???;
    localparam logic [7:0] OP_SECURITY_NONE = 8'hf0;
    localparam logic [7:0] OP_SECURITY_TOP = 8'hf7;
    localparam logic [7:0] OP_RD_NATIVE_MAX = 8'hf8;
    localparam logic [7:0] OP_SET_MAX = 8'hf9;

    typedef struct packed {
        logic sc;
        logic sn;
        logic cy;
        logic drv;
        logic hd;
        logic ft;
    } param_use_t;

    typedef struct packed {
        logic [7:0] sector_count_param;
        logic [7:0] sector_number_param;
        logic [15:0] cylinder_param;
        logic drive_select_param;
        logic [3:0] head_select_param;
        logic [7:0] feature_param;
    } cmd_params_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic long_xfer;
        cmd_params_t params;
    } cmd_req_t;

    typedef struct packed {
        logic df;
        logic dsc;
        logic drq;
        logic idx;
    } drive_status_t;
endpackage

// [rtl/opcode_decoder.sv]
module opcode_decoder
    import task_file_pkg::*;
(
    // Opcode in
    input wire logic [7:0] opcode,
    // Decode out
    output logic valid,
    output logic long_xfer,
    output param_use_t use_mask
);
    localparam param_use_t USE_NONE = '{sc: 1'b0, sn: 1'b0, cy: 1'b0, drv: 1'b1, hd: 1'b0, ft: 1'b0};
    localparam param_use_t USE_XFER = '{sc: 1'b1, sn: 1'b1, cy: 1'b1, drv: 1'b1, hd: 1'b1, ft: 1'b0};
    localparam param_use_t USE_SEEK = '{sc: 1'b0, sn: 1'b0, cy: 1'b1, drv: 1'b1, hd: 1'b1, ft: 1'b0};
    localparam param_use_t USE_INIT = '{sc: 1'b1, sn: 1'b0, cy: 1'b0, drv: 1'b1, hd: 1'b1, ft: 1'b0};
    localparam param_use_t USE_SMART = '{sc: 1'b0, sn: 1'b0, cy: 1'b1, drv: 1'b1, hd: 1'b0, ft: 1'b1};
    localparam param_use_t USE_COUNT = '{sc: 1'b1, sn: 1'b0, cy: 1'b0, drv: 1'b1, hd: 1'b0, ft: 1'b0};
    localparam param_use_t USE_FEAT = '{sc: 1'b0, sn: 1'b0, cy: 1'b0, drv: 1'b1, hd: 1'b0, ft: 1'b1};

    always_comb begin
        valid = 1'b1;
        long_xfer = 1'b0;
        use_mask = USE_NONE;
        casez (opcode)
            OP_NOP, OP_RECAL, OP_DIAG, OP_RD_BUFFER, OP_FLUSH, OP_WR_BUFFER, OP_IDENTIFY,
            OP_RD_NATIVE_MAX: begin
                use_mask = USE_NONE;
            end
            OP_RW_SECTORS, OP_WR_SECTORS: begin
                use_mask = USE_XFER;
                long_xfer = opcode[LONG_BIT];
            end
            OP_WR_VERIFY, OP_RD_VERIFY, OP_RW_MULTIPLE, OP_DMA, OP_SET_MAX: begin
                use_mask = USE_XFER;
            end
            OP_FORMAT, OP_SEEK: begin
                use_mask = USE_SEEK;
            end
            OP_INIT_PARAMS: begin
                use_mask = USE_INIT;
            end
            OP_SMART: begin
                use_mask = USE_SMART;
            end
            OP_SET_MULTIPLE, OP_PWR_ALT_LO, OP_PWR_ALT_HI, OP_PWR_MAIN, OP_CHECK_PWR, OP_SLEEP: begin
                use_mask = USE_COUNT;
            end
            OP_SET_FEATURES: begin
                use_mask = USE_FEAT;
            end
            OP_SECURITY: begin
                valid = (opcode != OP_SECURITY_NONE) && (opcode != OP_SECURITY_TOP);
            end
            default: begin
                valid = 1'b0;
            end
        endcase
    end
endmodule // opcode_decoder

// [verification/host_adapter.sv]
module host_adapter (
    // Clock
    input wire logic sys_clk,
    // Task-file bus driven toward the drive
    output logic cs0_n,
    output logic cs1_n,
    output logic [2:0] addr,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] wr_data,
    // Read answer
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        addr = 3'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wr_data = 8'h00;
    end

    // One access per call; released address and data lines show the inverse of the last value
    task automatic access(input logic sel1, input logic [2:0] a, input logic wr, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(negedge sys_clk);
        cs0_n = sel1;
        cs1_n = !sel1;
        addr = a;
        wr_data = d;
        wr_en = wr;
        rd_en = !wr;
        @(posedge sys_clk);
        #1 ok = rd_valid;
        q = rd_data;
        @(negedge sys_clk);
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        addr = ~a;
        wr_data = ~d;
        wr_en = 1'b0;
        rd_en = 1'b0;
        for (int i = 0; i < 2 && !wr && ok !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1 ok = rd_valid;
            q = rd_data;
        end
    endtask
endmodule // host_adapter

// [verification/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import task_file_pkg::*;

    logic sys_clk;
    logic rst;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] addr;
    logic rd_en;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_valid;
    logic dev_id;
    logic drive_ready;
    drive_status_t drv_status;
    logic cmd_done;
    logic cmd_err;
    logic cmd_start;
    cmd_req_t cmd_req;
    logic soft_reset;
    logic intrq_out;
    logic intrq_oe;
    int n_errors = 0;
    int checks = 0;
    int starts = 0;
    cmd_req_t last_req;

    task_file_port dut (.sys_clk(sys_clk), .rst(rst), .cs0_n(cs0_n), .cs1_n(cs1_n), .addr(addr),
        .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .dev_id(dev_id), .drive_ready(drive_ready), .drv_status(drv_status), .cmd_done(cmd_done),
        .cmd_err(cmd_err), .cmd_start(cmd_start), .cmd_req(cmd_req), .soft_reset(soft_reset),
        .intrq_out(intrq_out), .intrq_oe(intrq_oe));

    host_adapter host (.sys_clk(sys_clk), .cs0_n(cs0_n), .cs1_n(cs1_n), .addr(addr), .rd_en(rd_en),
        .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (cmd_start === 1'b1) begin
            starts <= starts + 1;
            last_req <= cmd_req;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input logic sel1, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        host.access(sel1, a, 1'b1, d, q, ok);
    endtask

    task automatic rd(input logic sel1, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        host.access(sel1, a, 1'b0, 8'h00, q, ok);
        check(ok, 1'b1);
        check(q, exp);
    endtask

    task automatic finish_cmd(input logic err);
        @(negedge sys_clk);
        cmd_done = 1'b1;
        cmd_err = err;
        @(negedge sys_clk);
        cmd_done = 1'b0;
        cmd_err = 1'b0;
        cyc(1);
    endtask

    task automatic t_reset;
        cyc(2);
        check({rd_valid, cmd_start, soft_reset, intrq_out, intrq_oe}, 5'h01);
        check(cmd_req, '0);
        rd(1'b0, ADDR_STATUS, 8'h52);
        $display("reset test done");
    endtask

    task automatic t_params;
        wr(1'b0, ADDR_FEATURES, 8'ha5);
        wr(1'b0, ADDR_SECTOR_COUNT, 8'h11);
        wr(1'b0, ADDR_SECTOR_NUMBER, 8'h22);
        wr(1'b0, ADDR_CYL_LOW, 8'h34);
        wr(1'b0, ADDR_CYL_HIGH, 8'h12);
        wr(1'b0, ADDR_DRIVE_HEAD, 8'hf5);
        wr(1'b0, ADDR_COMMAND, OP_SET_MAX);
        cyc(2);
        check(last_req, {8'hf9, 1'b0, 8'h11, 8'h22, 16'h1234, 1'b1, 4'h5, 8'h00});
        finish_cmd(1'b0);
        check(intrq_out, 1'b1);
        rd(1'b1, ADDR_ALT_STATUS, 8'h52);
        check(intrq_out, 1'b1);
        rd(1'b0, ADDR_STATUS, 8'h52);
        cyc(1);
        check(intrq_out, 1'b0);
        wr(1'b0, ADDR_COMMAND, OP_NOP);
        cyc(2);
        check(last_req, {8'h00, 1'b0, 8'h00, 8'h00, 16'h0000, 1'b1, 4'h0, 8'h00});
        finish_cmd(1'b0);
        wr(1'b0, ADDR_COMMAND, OP_SMART);
        cyc(2);
        check(last_req, {8'hb0, 1'b0, 16'h0000, 16'h1234, 1'b1, 4'h0, 8'ha5});
        finish_cmd(1'b0);
        $display("parameter test done");
    endtask

    task automatic t_busy;
        int n;
        wr(1'b0, ADDR_COMMAND, 8'h20);
        cyc(1);
        n = starts;
        rd(1'b0, ADDR_STATUS, 8'hd2);
        rd(1'b0, ADDR_ERROR, 8'hd2);
        wr(1'b0, ADDR_COMMAND, OP_NOP);
        cyc(2);
        check(starts, n);
        finish_cmd(1'b0);
        rd(1'b0, ADDR_STATUS, 8'h52);
        $display("busy test done");
    endtask

    task automatic t_codes;
        logic [7:0] codes [0:29] = '{8'h00, 8'h1f, 8'h20, 8'h23, 8'h32, 8'h3c, 8'h41, 8'h50, 8'h7a,
            8'h90, 8'h91, 8'h94, 8'h99, 8'hb0, 8'hc4, 8'hc6, 8'hc9, 8'hcb, 8'he0, 8'he3, 8'he4, 8'he5,
            8'he7, 8'he8, 8'hec, 8'hef, 8'hf1, 8'hf6, 8'hf8, 8'hf9};
        int n;
        n = starts;
        foreach (codes[i]) begin
            wr(1'b0, ADDR_COMMAND, codes[i]);
            cyc(2);
            check(starts, n + i + 1);
            check({last_req.opcode, last_req.long_xfer}, {codes[i], (codes[i] & 8'hee) == 8'h22});
            finish_cmd(1'b0);
        end
        $display("opcode test done");
    endtask

    task automatic t_invalid;
        logic [7:0] bad [0:4] = '{8'h01, 8'h60, 8'hf0, 8'hf7, 8'hff};
        int n;
        n = starts;
        foreach (bad[i]) begin
            wr(1'b0, ADDR_COMMAND, bad[i]);
            cyc(2);
            check({starts == n, intrq_out}, 2'h3);
            rd(1'b0, ADDR_ERROR, 8'h04);
        end
        drive_ready = 1'b0;
        wr(1'b0, ADDR_COMMAND, OP_NOP);
        cyc(2);
        check({starts == n, intrq_out}, 2'h3);
        drive_ready = 1'b1;
        wr(1'b0, ADDR_COMMAND, OP_NOP);
        cyc(2);
        check({starts == n + 1, intrq_out}, 2'h2);
        finish_cmd(1'b0);
        $display("invalid opcode test done");
    endtask

    task automatic t_srst;
        // Drive/head selects the other drive while soft reset is applied
        wr(1'b1, ADDR_DEVICE_CONTROL, 8'h0c);
        cyc(3);
        check(soft_reset, 1'b1);
        check(intrq_out, 1'b0);
        rd(1'b1, ADDR_ALT_STATUS, 8'hd2);
        dev_id = 1'b1;
        wr(1'b1, ADDR_DEVICE_CONTROL, 8'h08);
        cyc(3);
        check({soft_reset, intrq_oe}, 2'h0);
        dev_id = 1'b0;
        wr(1'b1, ADDR_DEVICE_CONTROL, 8'hfa);
        cyc(3);
        check(intrq_oe, 1'b0);
        wr(1'b1, ADDR_DEVICE_CONTROL, 8'hf9);
        cyc(3);
        check(intrq_oe, 1'b1);
        wr(1'b0, ADDR_COMMAND, OP_SET_MAX);
        cyc(2);
        check(last_req, {8'hf9, 46'h0});
        finish_cmd(1'b0);
        $display("soft reset test done");
    endtask

    initial begin
        #200000;
        n_errors++;
        stop_test;
    end

    initial begin
        rst = 1'b1;
        dev_id = 1'b0;
        drive_ready = 1'b1;
        drv_status = 4'b0101;
        cmd_done = 1'b0;
        cmd_err = 1'b0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_reset;
        t_params;
        t_busy;
        t_codes;
        t_invalid;
        t_srst;
        stop_test;
    end
endmodule // testbench
